// [hdl/trl_params.svh]
// Purpose: constants of the tap ram init loader
// Assumes: included by the loader module, checker and bench
// Notes:   opcodes are tap instruction values
`ifndef TRL_PARAMS_SVH
`define TRL_PARAMS_SVH

// user opcode window of the tap instruction register
`define TRL_OP_USER_LO  8'h10
`define TRL_OP_USER_HI  8'h7f
// start and stop of initialisation
`define TRL_OP_START    8'h22
`define TRL_OP_STOP     8'h23
// shift a write address instead of counting
`define TRL_OP_ADDR     8'h24
// first per-block opcode; block k uses base + k
`define TRL_OP_BLK_BASE 8'h40
// write address counter preset: all ones, so the first word lands at zero
`define TRL_WADDR_RST   1'b1
// read address counter reset
`define TRL_RADDR_RST   1'b0
// ring select reset: block zero selected
`define TRL_SEL_RST     1'b1

`endif

// [hdl/trl_pkg.sv]
// Purpose: types of the tap ram init loader
// Assumes: nothing beyond the params header
// Notes:   widths of data and address stay module parameters
package trl_pkg;

    // block selection scheme, one-hot codes
    typedef enum logic [2:0] {
        TRL_SEL_RING   = 3'h1,  // ring counter walks the blocks
        TRL_SEL_SHARED = 3'h2,  // one enable writes every block
        TRL_SEL_OPCODE = 3'h4   // each block has its own opcode
    } trl_sel_mode_t;

    // decoded instruction value
    typedef struct packed {
        logic       user;   // inside the user opcode window
        logic       start;  // start opcode
        logic       stop;   // stop opcode
        logic       addr;   // address shift opcode
        logic [7:0] blk;    // per-block index (value minus base)
    } trl_op_dec_t;

endpackage

// [hdl/trl_ram_init_loader.sv]
// Purpose: load ram blocks from the tap user bridge, with read-back
// Assumes: bridge_dr_clock is the tap clock, bridge signals live on it
// Notes:   shifted words cross to clk while update is high
//
// Function
// - opcode 34 starts, 35 stops loading
// - serial-in word register, ram data width
// - shift on dr clock while shift high
// - full word goes to ram via pipeline
// - internal counter sweeps write addresses
// - optional address shifted in, own opcode
// - shared enable writes all blocks together
// - ring select advances after last address while addr_shifted is low
// - instruction value governs counters and selects
// - write only while start opcode matches, or a block opcode in opcode select
// - update rise presents new data, address
// - write clock is inverted update flag
// - falling-edge rams take update uninverted
// - data, address, enables change together
// - one clock output: write or test
// - read-back sweeps every address of the one shared read port
// - read-back needs test input and stop
// - write ports move only on opcodes
`timescale 1ns/10ps
`include "trl_params.svh"
`default_nettype none

module trl_ram_init_loader
    import trl_pkg::*;
#(
    parameter int            DATA_W   = 4,   // ram data width
    parameter int            ADDR_W   = 2,   // ram address width
    parameter int            NUM_BLK  = 1,   // ram blocks served
    parameter bit            FALL_WCLK = 1'b0 // rams write on falling edge
) (
    input  wire logic                clk,
    input  wire logic                srst,
    // tap user bridge side
    input  wire logic                bridge_dr_clock,
    input  wire logic                bridge_reset_n,
    input  wire logic [7:0]          bridge_instr_value,
    input  wire logic                bridge_dr_shift,
    input  wire logic                bridge_update_state_flag,
    input  wire logic                bridge_serial_in,
    output logic                     bridge_serial_out,
    // static mode straps
    input  wire trl_sel_mode_t       sel_mode,
    input  wire logic                addr_shifted,
    // read-back test
    input  wire logic                test_en,
    input  wire logic                test_clk,
    input  wire logic [DATA_W-1:0]   read_word,
    output logic      [DATA_W-1:0]   test_out,
    // ram ports
    output logic                     ram_clk_out,
    output logic      [DATA_W-1:0]   ram_wr_data,
    output logic      [ADDR_W-1:0]   ram_wr_addr,
    output logic      [NUM_BLK-1:0]  ram_wr_en,
    output logic      [ADDR_W-1:0]   ram_rd_addr,
    output logic                     ram_rd_en_n
);

    // decode an instruction value; used on both clocks
    function automatic trl_op_dec_t op_decode(input logic [7:0] v);
        trl_op_dec_t d;
        d       = '0;
        d.user  = (v >= `TRL_OP_USER_LO) && (v <= `TRL_OP_USER_HI);
        d.start = (v == `TRL_OP_START);
        d.stop  = (v == `TRL_OP_STOP);
        d.addr  = (v == `TRL_OP_ADDR);
        d.blk   = v - `TRL_OP_BLK_BASE;
        return d;
    endfunction

    // ---------------- link side, tap clock ----------------
    trl_op_dec_t               op_link;     // decode in tap domain
    logic [DATA_W-1:0]         data_sr_r;   // serial-in data word
    logic [ADDR_W-1:0]         addr_sr_r;   // serial-in address word
    logic                      tdo_r;       // serial out flop

    // bridge instruction value is already on the tap clock
    always_comb begin
        op_link = op_decode(bridge_instr_value);
    end

    // data word shift; held while the address opcode is loaded
    always_ff @(posedge bridge_dr_clock or negedge bridge_reset_n) begin
        if (!bridge_reset_n) begin
            data_sr_r <= '0;
        end else if (bridge_dr_shift && !op_link.addr) begin
            // msb first out, lsb in, as a plain sipo
            data_sr_r <= {data_sr_r[DATA_W-2:0], bridge_serial_in};
        end
    end

    // address word shift under its own opcode
    always_ff @(posedge bridge_dr_clock or negedge bridge_reset_n) begin
        if (!bridge_reset_n) begin
            addr_sr_r <= '0;
        end else if (bridge_dr_shift && op_link.addr) begin
            addr_sr_r <= {addr_sr_r[ADDR_W-2:0], bridge_serial_in};
        end
    end

    // serial out copies the msb of the active word
    // one tap clock late, which keeps the port a flop
    always_ff @(posedge bridge_dr_clock or negedge bridge_reset_n) begin
        if (!bridge_reset_n) begin
            tdo_r <= 1'b0;
        end else if (op_link.addr) begin
            tdo_r <= addr_sr_r[ADDR_W-1];
        end else begin
            tdo_r <= data_sr_r[DATA_W-1];
        end
    end

    assign bridge_serial_out = tdo_r;

    // ---------------- crossings into clk ----------------
    logic                rst_m_r;     // reset sync, first stage
    logic                rst_s_r;     // reset sync, usable
    logic                upd_m_r;     // update flag, first stage
    logic                upd_s_r;     // update flag, synced
    logic                upd_d_r;     // update flag, previous
    logic [7:0]          ins_m_r;     // instruction, first stage
    logic [7:0]          ins_s_r;     // instruction, synced
    logic [7:0]          ins_d_r;     // instruction, previous
    logic                tst_m_r;     // test input, first stage
    logic                tst_s_r;     // test input, synced
    logic                tck_m_r;     // test clock, first stage
    logic                tck_s_r;     // test clock, synced
    logic                tck_d_r;     // test clock, previous

    // bridge reset: asserts at once, releases on clk
    always_ff @(posedge clk or negedge bridge_reset_n) begin
        if (!bridge_reset_n) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // two-flop synchronisers; first stages feed nothing else
    always_ff @(posedge clk) begin
        if (srst) begin
            upd_m_r <= 1'b0;
            upd_s_r <= 1'b0;
            upd_d_r <= 1'b0;
            ins_m_r <= '0;
            ins_s_r <= '0;
            ins_d_r <= '0;
            tst_m_r <= 1'b0;
            tst_s_r <= 1'b0;
            tck_m_r <= 1'b0;
            tck_s_r <= 1'b0;
            tck_d_r <= 1'b0;
        end else begin
            upd_m_r <= bridge_update_state_flag;
            upd_s_r <= upd_m_r;
            upd_d_r <= upd_s_r;
            ins_m_r <= bridge_instr_value;
            ins_s_r <= ins_m_r;
            ins_d_r <= ins_s_r;
            tst_m_r <= test_en;
            tst_s_r <= tst_m_r;
            tck_m_r <= test_clk;
            tck_s_r <= tck_m_r;
            tck_d_r <= tck_s_r;
        end
    end

    // ---------------- ram side, clk ----------------
    trl_op_dec_t         op_clk;      // decode of synced value
    logic                ins_stable;  // two samples agree
    logic                commit;      // update flag rose
    logic                wr_on;       // some block may be written
    logic                test_active; // read-back running
    logic                last_addr;   // block fully addressed
    logic [NUM_BLK-1:0]  sel_r;       // ring select, one-hot
    logic [NUM_BLK-1:0]  sel_nxt;     // ring select after commit
    logic [NUM_BLK-1:0]  en_nxt;      // write enables to present
    logic [ADDR_W-1:0]   waddr_r;     // write address counter
    logic [ADDR_W-1:0]   raddr_r;     // read address counter
    logic [DATA_W-1:0]   wdata_r;     // pipeline data register
    logic [NUM_BLK-1:0]  wen_r;       // write enable register
    logic                clk_out_r;   // write or test clock
    logic                rden_n_r;    // read enable, low active
    logic [DATA_W-1:0]   tout_r;      // read-back data

    // a bus sampled mid-change may show a mix; wait for two equal
    always_comb begin
        op_clk     = op_decode(ins_s_r);
        ins_stable = (ins_s_r == ins_d_r);
    end

    // one word is complete when update rises
    always_comb begin
        commit = upd_s_r && !upd_d_r;
    end

    // writing is allowed only by the instruction value
    always_comb begin
        if (!ins_stable) begin
            wr_on = 1'b0;
        end else if (sel_mode == TRL_SEL_OPCODE) begin
            wr_on = op_clk.user && (op_clk.blk < 8'(NUM_BLK));
        end else begin
            wr_on = op_clk.start;
        end
    end

    // read-back only under the test input and stop opcode
    always_comb begin
        test_active = tst_s_r && ins_stable && op_clk.stop;
    end

    // with addr_shifted low, ring select moves on once the block's last address is written
    always_comb begin
        // the preset also reads all ones; only a written top address counts
        last_addr = (waddr_r == {ADDR_W{1'b1}}) && (|wen_r);
        sel_nxt   = sel_r;
        if (commit && wr_on && last_addr && !addr_shifted) begin
            // shift left with wrap; also holds for a single block
            sel_nxt = (sel_r << 1) | (sel_r >> (NUM_BLK - 1));
        end
    end

    // enables to present with the next word
    genvar gk;
    generate
        for (gk = 0; gk < NUM_BLK; gk++) begin : g_en
            always_comb begin
                en_nxt[gk] = 1'b0;
                if (wr_on) begin
                    unique case (sel_mode)
                        TRL_SEL_RING: begin
                            en_nxt[gk] = sel_nxt[gk];
                        end
                        TRL_SEL_SHARED: begin
                            en_nxt[gk] = 1'b1;
                        end
                        TRL_SEL_OPCODE: begin
                            en_nxt[gk] = (op_clk.blk == 8'(gk));
                        end
                        default: begin
                            // a strap outside the one-hot set writes nothing
                            en_nxt[gk] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ring select register
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_r <= NUM_BLK'(`TRL_SEL_RST);
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // write address: preset so the first commit gives zero
    always_ff @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            waddr_r <= {ADDR_W{`TRL_WADDR_RST}};
        end else if (srst) begin
            waddr_r <= {ADDR_W{`TRL_WADDR_RST}};
        end else if (ins_s_r != ins_d_r) begin
            // a new instruction restarts the sweep
            waddr_r <= {ADDR_W{`TRL_WADDR_RST}};
        end else if (commit && wr_on) begin
            if (addr_shifted) begin
                // word is quiet: shifting ended before update
                waddr_r <= addr_sr_r;
            end else begin
                waddr_r <= waddr_r + 1'b1;
            end
        end
    end

    // pipeline register takes the full word on update
    always_ff @(posedge clk) begin
        if (srst) begin
            wdata_r <= '0;
        end else if (commit && wr_on) begin
            wdata_r <= data_sr_r;
        end
    end

    // enables load on the same edge as data and address
    always_ff @(posedge clk) begin
        if (srst) begin
            wen_r <= '0;
        end else if (!wr_on) begin
            // no matching opcode: write ports stay idle
            wen_r <= '0;
        end else if (commit) begin
            wen_r <= en_nxt;
        end
    end

    // read address steps on the falling test clock edge,
    // so it has settled before the ram reads on the rise
    always_ff @(posedge clk) begin
        if (srst) begin
            raddr_r <= {ADDR_W{`TRL_RADDR_RST}};
        end else if (!test_active) begin
            raddr_r <= {ADDR_W{`TRL_RADDR_RST}};
        end else if (!tck_s_r && tck_d_r) begin
            raddr_r <= raddr_r + 1'b1;
        end
    end

    // single clock output: write clock or test read clock
    // the write clock edge lands as update falls, after data held
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_out_r <= !FALL_WCLK;
        end else if (test_active) begin
            clk_out_r <= tck_s_r;
        end else if (FALL_WCLK) begin
            clk_out_r <= upd_s_r;
        end else begin
            clk_out_r <= !upd_s_r;
        end
    end

    // read enable and read-back capture
    always_ff @(posedge clk) begin
        if (srst) begin
            rden_n_r <= 1'b1;
            tout_r   <= '0;
        end else begin
            rden_n_r <= !test_active;
            tout_r   <= read_word;
        end
    end

    assign ram_wr_data = wdata_r;
    assign ram_wr_addr = waddr_r;
    assign ram_wr_en   = wen_r;
    assign ram_rd_addr = raddr_r;
    assign ram_rd_en_n = rden_n_r;
    assign ram_clk_out = clk_out_r;
    assign test_out    = tout_r;

endmodule

`default_nettype wire

// [dv/trl_loader_checker.sv]
// Purpose: port assertions for the ram init loader
// Assumes: single clk domain, straps static between resets
// Notes:   commit lag follows the 2ff update synchroniser
`timescale 1ns/10ps
`include "trl_params.svh"
`default_nettype none
module trl_loader_checker
    import trl_pkg::*;
#(
    parameter int DATA_W  = 4,  // ram data width
    parameter int ADDR_W  = 2,  // ram address width
    parameter int NUM_BLK = 1   // ram blocks served
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [7:0]          bridge_instr_value,
    input  wire logic                bridge_update_state_flag,
    input  wire logic                test_en,
    input  wire trl_sel_mode_t       sel_mode,
    input  wire logic                addr_shifted,
    input  wire logic                ram_clk_out,
    input  wire logic [DATA_W-1:0]   ram_wr_data,
    input  wire logic [ADDR_W-1:0]   ram_wr_addr,
    input  wire logic [NUM_BLK-1:0]  ram_wr_en,
    input  wire logic                ram_rd_en_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // a commit: write clock falls while the write path owns the clock
    sequence commit_s;
        $fell(ram_clk_out) && ram_rd_en_n;
    endsequence
    // update flag rises at the bridge while no read-back runs
    sequence upd_rise_s;
        $rose(bridge_update_state_flag) && ram_rd_en_n;
    endsequence
    a_commit_lag: assert property (upd_rise_s |-> ##[2:4] !ram_clk_out)
        else $error("write clock did not fall after update rose");
    a_write_edge: assert property ($fell(bridge_update_state_flag) && ram_rd_en_n |-> ##[2:4] ram_clk_out)
        else $error("write clock did not rise after update fell");
    a_hold_low: assert property (ram_rd_en_n && !ram_clk_out && !$fell(ram_clk_out)
        |-> $stable(ram_wr_data) && $stable(ram_wr_addr) && $stable(ram_wr_en))
        else $error("write outputs moved while write clock low");
    a_data_moves: assert property ($changed(ram_wr_data) |-> $fell(ram_clk_out))
        else $error("write data changed away from a commit");
    a_addr_step: assert property ((commit_s ##0 (|ram_wr_en && $past(|ram_wr_en)))
        |-> ram_wr_addr == ADDR_W'($past(ram_wr_addr) + 1))
        else $error("write address did not step by one");
    a_first_zero: assert property ($rose(|ram_wr_en) && !addr_shifted |-> ram_wr_addr == '0)
        else $error("first write not at address zero");
    a_start_only: assert property ($rose(|ram_wr_en) && sel_mode != TRL_SEL_OPCODE
        |-> bridge_instr_value == `TRL_OP_START)
        else $error("write enabled without start opcode");
    a_ring_one: assert property (sel_mode == TRL_SEL_RING |-> $onehot0(ram_wr_en))
        else $error("ring select enabled more than one block");
    a_read_gate: assert property ($fell(ram_rd_en_n) |-> test_en && bridge_instr_value == `TRL_OP_STOP)
        else $error("read path opened without test and stop");
endmodule
bind trl_ram_init_loader trl_loader_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .NUM_BLK(NUM_BLK)) u_chk (
    .clk(clk), .srst(srst), .bridge_instr_value(bridge_instr_value), .bridge_update_state_flag(bridge_update_state_flag),
    .test_en(test_en), .sel_mode(sel_mode), .addr_shifted(addr_shifted), .ram_clk_out(ram_clk_out),
    .ram_wr_data(ram_wr_data), .ram_wr_addr(ram_wr_addr), .ram_wr_en(ram_wr_en), .ram_rd_en_n(ram_rd_en_n));
`default_nettype wire

// [dv/trl_tap_ram_model.sv]
// Purpose: tap bridge frames plus ram blocks behind the loader
// Assumes: 48 ns tap clock, running only inside frames
// Notes:   read data of a closed port is a non-value pattern
`timescale 1ns/10ps
`default_nettype none
module trl_tap_ram_model #(
    parameter int DATA_W  = 4,
    parameter int ADDR_W  = 2,
    parameter int NUM_BLK = 1
) (
    output var logic                dr_clock,
    output var logic                dr_shift,
    output var logic                update_state_flag,
    output var logic                serial_in,
    input  wire logic               serial_out,
    input  wire logic               ram_clk_out,
    input  wire logic [DATA_W-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0]  wr_addr,
    input  wire logic [NUM_BLK-1:0] wr_en,
    input  wire logic [ADDR_W-1:0]  rd_addr,
    input  wire logic               rd_en_n,
    output logic      [DATA_W-1:0]  read_word
);
    logic [DATA_W-1:0] mem [NUM_BLK][2**ADDR_W];  // ram contents
    initial begin
        dr_clock  = 1'b0;
        dr_shift  = 1'b0;
        update_state_flag = 1'b0;
        serial_in = 1'b0;
    end
    // ram write on rising write clock, only enabled blocks take it
    always @(posedge ram_clk_out) begin
        for (int k = 0; k < NUM_BLK; k++) begin
            if (rd_en_n && wr_en[k]) begin
                mem[k][wr_addr] = wr_data;
            end
        end
    end
    // closed read port shows all ones, never the stored word
    assign read_word = rd_en_n ? '1 : mem[0][rd_addr];
    // one frame: msb first, then update held well over 3 clk each way
    task automatic shift_word(input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] old);
        for (int i = DATA_W - 1; i >= 0; i--) begin
            serial_in = w[i];
            dr_shift  = 1'b1;
            #24 dr_clock = 1'b1;
            #24 dr_clock = 1'b0;
            old[i]    = serial_out;  // settled since the rising edge
        end
        dr_shift  = 1'b0;
        serial_in = ~serial_in;  // line idle: no stale bit
        #48 update_state_flag = 1'b1;
        #144 update_state_flag = 1'b0;
        #144;
    endtask
endmodule
`default_nettype wire

// [dv/trl_ram_init_loader_bench.sv]
// Purpose: self-checking bench for the ram init loader
// Assumes: two blocks, every select scheme, both address sources
// Notes:   tap frames come from the partner model
`timescale 1ns/10ps
`include "trl_params.svh"
`default_nettype none
module trl_ram_init_loader_bench;
    import trl_pkg::*;
    logic clk, srst, rst_n, dck, dsh, dup, sin, sout, ten, tck, cko, rd_en_n;
    logic ash;                         // address source strap
    logic [7:0] instr;                 // tap instruction value
    trl_sel_mode_t sel_mode;           // block select strap
    logic [3:0] rword, tout, wdata;
    logic [1:0] waddr, raddr, wen;
    logic [3:0] words [8] = '{4'h3, 4'ha, 4'h5, 4'hc, 4'h9, 4'h6, 4'hf, 4'h0};
    logic [3:0] old;                   // bits pushed out by a frame
    int n_fail = 0;
    int n_tests = 0;
    trl_ram_init_loader #(.NUM_BLK(2)) DUT (
        .clk(clk), .srst(srst), .bridge_dr_clock(dck), .bridge_reset_n(rst_n),
        .bridge_instr_value(instr), .bridge_dr_shift(dsh), .bridge_update_state_flag(dup),
        .bridge_serial_in(sin), .bridge_serial_out(sout), .sel_mode(sel_mode), .addr_shifted(ash),
        .test_en(ten), .test_clk(tck), .read_word(rword), .test_out(tout), .ram_clk_out(cko),
        .ram_wr_data(wdata), .ram_wr_addr(waddr), .ram_wr_en(wen), .ram_rd_addr(raddr),
        .ram_rd_en_n(rd_en_n));
    trl_tap_ram_model #(.NUM_BLK(2)) MDL (
        .dr_clock(dck), .dr_shift(dsh), .update_state_flag(dup), .serial_in(sin), .serial_out(sout),
        .ram_clk_out(cko), .wr_data(wdata), .wr_addr(waddr), .wr_en(wen), .rd_addr(raddr),
        .rd_en_n(rd_en_n), .read_word(rword));
    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // step n clocks, then land just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one compare for every port value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reset values at the ram ports
    task automatic t_reset;
        srst = 1'b1;
        rst_n = 1'b0;
        cyc(4);
        srst = 1'b0;
        rst_n = 1'b1;
        cyc(4);
        chk(waddr, 8'h3);
        chk(wen, 8'h0);
        chk(rd_en_n, 8'h1);
        chk(cko, 8'h1);
        chk(raddr, 8'h0);
        $display("reset test done");
    endtask
    // eight words: block 0 then block 1 on the wrapping commit
    task automatic t_load;
        instr = `TRL_OP_START;
        cyc(4);
        for (int i = 0; i < 8; i++) begin
            MDL.shift_word(words[i], old);
            cyc(1);
            chk(old, i == 0 ? 8'h0 : 8'(words[i-1]));
            chk(wdata, 8'(words[i]));
            chk(waddr, 8'(i % 4));
            chk(wen, i < 4 ? 8'h1 : 8'h2);
        end
        for (int a = 0; a < 4; a++) begin
            chk(MDL.mem[0][a], 8'(words[a]));
            chk(MDL.mem[1][a], 8'(words[a+4]));
        end
        $display("load test done");
    endtask
    // another user opcode: no write reaches the ram
    task automatic t_refuse;
        instr = 8'h10;
        cyc(5);
        MDL.shift_word(4'h7, old);
        cyc(1);
        chk(wen, 8'h0);
        chk(waddr, 8'h3);
        chk(MDL.mem[0][0], 8'(words[0]));
        $display("refuse test done");
    endtask
    // read every location of block 0 back
    task automatic t_readback;
        instr = `TRL_OP_STOP;
        ten = 1'b1;
        cyc(6);
        chk(rd_en_n, 8'h0);
        for (int a = 0; a < 4; a++) begin
            chk(raddr, 8'(a));
            tck = 1'b1;
            cyc(5);
            chk(cko, 8'h1);
            chk(tout, 8'(words[a]));
            tck = 1'b0;
            cyc(5);
            chk(cko, 8'h0);
        end
        chk(raddr, 8'h0);
        ten = 1'b0;
        cyc(6);
        chk(rd_en_n, 8'h1);
        chk(cko, 8'h1);
        $display("readback test done");
    endtask
    // shared enable, then block 1's own opcode
    task automatic t_modes;
        sel_mode = TRL_SEL_SHARED;
        instr = `TRL_OP_START;
        cyc(5);
        MDL.shift_word(4'hd, old);
        cyc(1);
        chk(wen, 8'h3);
        chk(MDL.mem[0][0], 8'hd);
        chk(MDL.mem[1][0], 8'hd);
        sel_mode = TRL_SEL_OPCODE;
        instr = `TRL_OP_BLK_BASE + 8'h1;
        cyc(5);
        MDL.shift_word(4'h4, old);
        cyc(1);
        chk(wen, 8'h2);
        chk(waddr, 8'h0);
        chk(MDL.mem[0][0], 8'hd);
        chk(MDL.mem[1][0], 8'h4);
        $display("modes test done");
    endtask
    // write address taken from its own shift frame
    task automatic t_addr_shift;
        sel_mode = TRL_SEL_RING;
        ash = 1'b1;
        instr = `TRL_OP_ADDR;
        cyc(5);
        MDL.shift_word(4'h2, old);
        instr = `TRL_OP_START;
        cyc(5);
        MDL.shift_word(4'hb, old);
        cyc(1);
        chk(waddr, 8'h2);
        chk(wdata, 8'hb);
        chk(MDL.mem[1][2], 8'hb);
        ash = 1'b0;
        $display("address shift test done");
    endtask
    // cut a hang short
    initial begin
        #200us;
        n_fail++;
        wrap_up();
    end
    initial begin
        srst = 1'b1;
        rst_n = 1'b0;
        instr = 8'h00;
        ten = 1'b0;
        tck = 1'b0;
        ash = 1'b0;
        sel_mode = TRL_SEL_RING;
        @(posedge clk);
        #1;
        t_reset();
        t_load();
        t_refuse();
        t_readback();
        t_modes();
        t_addr_shift();
        wrap_up();
    end
endmodule
`default_nettype wire
